// ### inc/vxp_pkg.sv
`default_nettype none

package vxp_pkg;

    // -------------------------------------------------------------------------
    // Stream bytes
    // -------------------------------------------------------------------------
    localparam logic [7:0]  CODE_PRE_FF  = 8'hFF;
    localparam logic [7:0]  CODE_PRE_00  = 8'h00;
    localparam logic [7:0]  BLANK_LO     = 8'h80;
    localparam logic [7:0]  BLANK_HI     = 8'h10;

    // -------------------------------------------------------------------------
    // Output timing code modes
    // -------------------------------------------------------------------------
    localparam logic [2:0]  OTC_ITU      = 3'h0;
    localparam logic [2:0]  OTC_VERTICAL_GATE_WINDOW    = 3'h1;
    localparam logic [2:0]  OTC_NOCODE   = 3'h2;

    // -------------------------------------------------------------------------
    // Vertical timing, line numbers
    // -------------------------------------------------------------------------
    localparam logic [9:0]  LINE_FIRST   = 10'h001;
    localparam logic [9:0]  LINES_525    = 10'h20D;
    localparam logic [9:0]  LINES_625    = 10'h271;
    localparam logic [9:0]  L525_F1_END  = 10'h003;
    localparam logic [9:0]  L525_F2_BEG  = 10'h10A;
    localparam logic [9:0]  L525_V1_END  = 10'h013;
    localparam logic [9:0]  L525_V2_BEG  = 10'h108;
    localparam logic [9:0]  L525_V2_END  = 10'h11A;
    localparam logic [9:0]  L625_F_BEG   = 10'h139;
    localparam logic [9:0]  L625_V1_END  = 10'h016;
    localparam logic [9:0]  L625_V2_BEG  = 10'h137;
    localparam logic [9:0]  L625_V2_END  = 10'h14F;
    localparam logic [9:0]  L625_V3_BEG  = 10'h270;

    // -------------------------------------------------------------------------
    // Horizontal layout in bytes
    // -------------------------------------------------------------------------
    localparam logic [10:0] LINE_B525    = 11'h6B4;
    localparam logic [10:0] LINE_B625    = 11'h6C0;
    localparam logic [10:0] ACTIVE_B     = 11'h5A0;
    localparam logic [10:0] CODE_LEN     = 11'h004;

    // -------------------------------------------------------------------------
    // Trigger edge selection
    // -------------------------------------------------------------------------
    localparam logic [1:0]  EDGE_RISE    = 2'h1;
    localparam logic [1:0]  EDGE_FALL    = 2'h2;
    localparam logic [1:0]  EDGE_BOTH    = 2'h3;

    localparam logic [1:0]  SRC_PORT     = 2'h1;

    typedef enum logic [1:0] {
        ST_EAV   = 2'b00,
        ST_BLANK = 2'b01,
        ST_SAV   = 2'b11,
        ST_ACT   = 2'b10
    } vxp_ost_e;

endpackage : vxp_pkg

`default_nettype wire

// ### verilog/vxp_port.sv
`timescale 1ns/100ps
`default_nettype none

module vxp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic      [WIDTH-1:0] o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH)
        $error("vxp_fifo: DEPTH must be a power of two");

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             wr;
    logic             rd;

    assign o_ready = cnt_q != (AW+1)'(DEPTH);
    assign o_valid = cnt_q != '0;
    assign o_data  = mem[rd_q];
    assign wr      = i_valid && o_ready;
    assign rd      = o_valid && i_ready;

    always_ff @(posedge i_clk)
    begin
        if (wr)
            mem[wr_q] <= i_data;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q  <= wr ? wr_q + 1'b1 : wr_q;
            rd_q  <= rd ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
        end
    end
endmodule : vxp_fifo

module vxp_port
    import vxp_pkg::*;
#(
    parameter int PIX_DIV = 4,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic       I_REF_CLK,
    input  wire logic       I_SRST,
    input  wire logic       I_PORT_OUT_EN,
    input  wire logic       I_STD_625,
    input  wire logic [2:0] I_OUTPUT_TIMING_CODE_SELECT,
    input  wire logic [9:0] I_VERTICAL_GATE_WINDOW_START_LINE,
    input  wire logic [9:0] I_VERTICAL_GATE_WINDOW_STOP_LINE,
    input  wire logic [7:0] I_DEC_DATA,
    input  wire logic       I_DEC_VALID,
    output logic            O_DEC_READY,
    output logic [7:0]      O_PORT_DATA_BUS,
    output logic            O_PORT_DATA_BUS_OE,
    output logic            O_FIELD,
    output logic            O_VBLANK,
    input  wire logic [7:0] I_PORT_DATA_BUS,
    input  wire logic       I_PORT_CLOCK,
    input  wire logic       I_PORT_QUALIFIER,
    input  wire logic       I_PORT_HORIZONTAL_REF,
    input  wire logic       I_PORT_VERTICAL_REF,
    input  wire logic       I_EMBEDDED_CODES,
    input  wire logic [1:0] I_SCALER_SOURCE_SELECT,
    input  wire logic [2:0] I_INPUT_FORMAT_SELECT,
    input  wire logic [1:0] I_FIELD_DETECT_VERTICAL_CFG,
    input  wire logic [1:0] I_FIELD_DETECT_HORIZONTAL_CFG,
    input  wire logic [3:0] I_VERTICAL_TRIGGER_EDGE_CFG,
    input  wire logic [1:0] I_HORIZONTAL_TRIGGER_EDGE_CFG,
    input  wire logic [1:0] I_QUALIFIER_POLARITY,
    input  wire logic [1:0] I_GATED_CLOCK_MODE,
    output logic            O_PORT_READY,
    output logic [7:0]      O_SCL_DATA,
    output logic            O_SCL_FIELD,
    output logic            O_SCL_VALID,
    input  wire logic       I_SCL_READY,
    output logic [2:0]      O_SCL_FORMAT,
    output logic [1:0]      O_H_TRIG,
    output logic [1:0]      O_V_TRIG,
    output logic [1:0]      O_IN_FIELD,
    output logic [7:0]      O_VBI_DATA,
    output logic            O_VBI_VALID
);
    if (PIX_DIV < 1)
        $error("vxp_port: PIX_DIV must be at least 1");

    localparam int DW = $clog2(PIX_DIV + 1);
    localparam int CLK_B = 8;
    localparam int QUAL_B = 9;
    localparam int HREF_B = 10;
    localparam int VREF_B = 11;

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    function automatic logic [1:0] fv_of(input logic [9:0] ln, input logic is625,
                                         input logic alt, input logic [9:0] vs,
                                         input logic [9:0] ve);
        logic f;
        logic v;
        if (is625)
        begin
            f = ln >= L625_F_BEG;
            v = ln <= L625_V1_END || (ln >= L625_V2_BEG && ln <= L625_V2_END)
                || ln >= L625_V3_BEG;
        end
        else
        begin
            f = ln <= L525_F1_END || ln >= L525_F2_BEG;
            v = ln <= L525_V1_END || (ln >= L525_V2_BEG && ln <= L525_V2_END);
        end
        if (alt)
            v = ln < vs || ln >= ve;
        return {f, v};
    endfunction : fv_of

    function automatic logic edge_hit(input logic [1:0] cfg, input logic r, input logic f);
        case (cfg)
            EDGE_RISE: return r;
            EDGE_FALL: return f;
            EDGE_BOTH: return r | f;
            default:   return 1'b0;
        endcase
    endfunction : edge_hit

    // -------------------------------------------------------------------------
    // Output stream generator
    // -------------------------------------------------------------------------
    logic [DW-1:0] div_q;
    logic          pix_en_q;
    vxp_ost_e      st_q;
    logic [10:0]   byte_q;
    logic [9:0]    line_q;
    logic          f_q;
    logic          v_q;
    logic          std_q;
    logic          alt_q;
    logic [9:0]    vs_q;
    logic [9:0]    ve_q;
    logic [7:0]    out_q;
    logic          oe_q;
    logic          code_q;
    logic          act_q;
    logic [10:0]   line_len;
    logic [10:0]   sav_pos;
    logic          line_end;
    logic [9:0]    next_line;
    logic          nocode;
    logic [7:0]    code_byte;
    logic [7:0]    blank_byte;

    assign line_len   = std_q ? LINE_B625 : LINE_B525;
    assign sav_pos    = line_len - ACTIVE_B - CODE_LEN;
    assign line_end   = byte_q >= line_len - 11'h1;
    assign next_line  = line_q >= (std_q ? LINES_625 : LINES_525) ? LINE_FIRST : line_q + 10'h1;
    assign nocode     = I_OUTPUT_TIMING_CODE_SELECT == OTC_NOCODE;
    assign blank_byte = byte_q[0] ? BLANK_HI : BLANK_LO;

    always_comb
    begin
        case (byte_q[1:0])
            2'h0:    code_byte = CODE_PRE_FF;
            2'h3:    code_byte = {1'b1, f_q, v_q, st_q == ST_EAV,
                                  v_q ^ (st_q == ST_EAV), f_q ^ (st_q == ST_EAV),
                                  f_q ^ v_q, f_q ^ v_q ^ (st_q == ST_EAV)};
            default: code_byte = CODE_PRE_00;
        endcase
    end

    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST || div_q >= DW'(PIX_DIV - 1))
            div_q <= '0;
        else
            div_q <= div_q + 1'b1;
        pix_en_q <= !I_SRST && div_q == '0;
    end

    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
        begin
            st_q   <= ST_EAV;
            byte_q <= '0;
        end
        else if (pix_en_q)
        begin
            byte_q <= line_end ? 11'h0 : byte_q + 11'h1;
            case (st_q)
                ST_EAV:   st_q <= byte_q >= CODE_LEN - 11'h1 ? ST_BLANK : ST_EAV;
                ST_BLANK: st_q <= byte_q >= sav_pos - 11'h1 ? ST_SAV : ST_BLANK;
                ST_SAV:   st_q <= byte_q >= sav_pos + CODE_LEN - 11'h1 ? ST_ACT : ST_SAV;
                ST_ACT:   st_q <= line_end ? ST_EAV : ST_ACT;
                default:  st_q <= ST_EAV;
            endcase
        end
    end

    // Line settings are latched at the line boundary so flags move only with EAV
    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
        begin
            line_q <= LINE_FIRST;
            // Line 1 of 525-line timing is second field and blanked
            {f_q, v_q} <= 2'h3;
            std_q  <= 1'b0;
            alt_q  <= 1'b0;
            vs_q   <= '0;
            ve_q   <= '0;
        end
        else if (pix_en_q && st_q == ST_ACT && line_end)
        begin
            line_q <= next_line;
            {f_q, v_q} <= fv_of(next_line, I_STD_625,
                                I_OUTPUT_TIMING_CODE_SELECT == OTC_VERTICAL_GATE_WINDOW,
                                I_VERTICAL_GATE_WINDOW_START_LINE, I_VERTICAL_GATE_WINDOW_STOP_LINE);
            std_q  <= I_STD_625;
            alt_q  <= I_OUTPUT_TIMING_CODE_SELECT == OTC_VERTICAL_GATE_WINDOW;
            vs_q   <= I_VERTICAL_GATE_WINDOW_START_LINE;
            ve_q   <= I_VERTICAL_GATE_WINDOW_STOP_LINE;
        end
    end

    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
        begin
            out_q  <= BLANK_LO;
            oe_q   <= 1'b0;
            code_q <= 1'b0;
            act_q  <= 1'b0;
        end
        else
        begin
            oe_q <= I_PORT_OUT_EN;
            if (pix_en_q)
            begin
                act_q  <= st_q == ST_ACT;
                code_q <= (st_q == ST_EAV || st_q == ST_SAV) && !nocode;
                if (st_q == ST_ACT)
                    out_q <= I_DEC_DATA;
                else if (st_q == ST_BLANK || nocode)
                    out_q <= blank_byte;
                else
                    out_q <= code_byte;
            end
        end
    end

    assign O_PORT_DATA_BUS    = out_q;
    assign O_PORT_DATA_BUS_OE = oe_q;
    assign O_FIELD            = f_q;
    assign O_VBLANK           = v_q;

    // -------------------------------------------------------------------------
    // Input pin synchronisers
    // -------------------------------------------------------------------------
    logic [11:0] pin_s1;
    logic [11:0] pin_s2;
    logic [11:0] pin_s3;
    logic [11:0] lvl_q;
    logic [11:0] lvl_d;
    logic [11:0] pin_rise;
    logic [11:0] pin_fall;

    // A pin level is taken over only where the last two stages agree
    assign lvl_d    = (pin_s2 & ~(pin_s2 ^ pin_s3)) | (lvl_q & (pin_s2 ^ pin_s3));
    assign pin_rise = lvl_d & ~lvl_q;
    assign pin_fall = ~lvl_d & lvl_q;

    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            lvl_q  <= '0;
        end
        else
        begin
            pin_s1 <= {I_PORT_VERTICAL_REF, I_PORT_HORIZONTAL_REF, I_PORT_QUALIFIER,
                       I_PORT_CLOCK, I_PORT_DATA_BUS};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            lvl_q  <= lvl_d;
        end
    end

    // -------------------------------------------------------------------------
    // Input capture, embedded codes, triggers and field; path 0 scaler, 1 VBI
    // -------------------------------------------------------------------------
    logic [1:0]  acc;
    logic [1:0]  acc_q;
    logic [7:0]  byte_q_in;
    logic [23:0] hist_q;
    logic        code_hit;
    logic        emb_f_q;
    logic        emb_v_q;
    logic        emb_vr;
    logic        emb_vf;
    logic        emb_sav;
    logic        v_r;
    logic        v_f;
    logic [1:0]  fld_q;
    logic [1:0]  h_trig_q;
    logic [1:0]  v_trig_q;

    // Gated clock mode: every rising clock edge carries data; otherwise qualifier with polarity
    assign acc = {2{pin_rise[CLK_B] && !I_PORT_OUT_EN}}
                 & (I_GATED_CLOCK_MODE
                    | ({2{lvl_d[QUAL_B]}} ^ I_QUALIFIER_POLARITY));
    assign code_hit = acc[0] && hist_q == {CODE_PRE_FF, CODE_PRE_00, CODE_PRE_00};
    // Only bits 6 to 4 of a received status byte are used
    assign emb_vr   = code_hit && lvl_d[5] && !emb_v_q;
    assign emb_vf   = code_hit && !lvl_d[5] && emb_v_q;
    assign emb_sav  = code_hit && !lvl_d[4];
    assign v_r      = I_EMBEDDED_CODES ? emb_vr : pin_rise[VREF_B];
    assign v_f      = I_EMBEDDED_CODES ? emb_vf : pin_fall[VREF_B];

    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
        begin
            acc_q     <= '0;
            byte_q_in <= '0;
            hist_q    <= '0;
            emb_f_q   <= 1'b0;
            emb_v_q   <= 1'b0;
        end
        else
        begin
            acc_q <= acc;
            if (acc != '0)
                byte_q_in <= lvl_d[7:0];
            if (acc[0])
                hist_q <= {hist_q[15:0], lvl_d[7:0]};
            if (code_hit)
            begin
                emb_f_q <= lvl_d[6];
                emb_v_q <= lvl_d[5];
            end
        end
    end

    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
        begin
            fld_q    <= '0;
            h_trig_q <= '0;
            v_trig_q <= '0;
        end
        else
        begin
            for (int p = 0; p < 2; p++)
            begin
                h_trig_q[p] <= I_EMBEDDED_CODES ? emb_sav :
                               I_HORIZONTAL_TRIGGER_EDGE_CFG[p] ? pin_fall[HREF_B] : pin_rise[HREF_B];
                v_trig_q[p] <= edge_hit(I_VERTICAL_TRIGGER_EDGE_CFG[2*p +: 2], v_r, v_f);
                if (I_EMBEDDED_CODES)
                    fld_q[p] <= code_hit ? lvl_d[6] : fld_q[p];
                else if (I_FIELD_DETECT_VERTICAL_CFG[p])
                    fld_q[p] <= lvl_d[VREF_B];
                else if (pin_rise[VREF_B])
                    fld_q[p] <= lvl_d[HREF_B] ^ I_FIELD_DETECT_HORIZONTAL_CFG[p];
            end
        end
    end

    assign O_H_TRIG     = h_trig_q;
    assign O_V_TRIG     = v_trig_q;
    assign O_IN_FIELD   = fld_q;
    assign O_VBI_DATA   = byte_q_in;
    assign O_VBI_VALID  = acc_q[1];
    assign O_SCL_FORMAT = I_INPUT_FORMAT_SELECT;

    // -------------------------------------------------------------------------
    // Scaler source selection and buffer
    // -------------------------------------------------------------------------
    logic       port_sel;
    logic       fifo_rdy;
    logic       push;
    logic [8:0] push_data;

    // Port samples have no stall; the ready output lets the sender hold off
    assign port_sel    = !I_PORT_OUT_EN && I_SCALER_SOURCE_SELECT == SRC_PORT;
    assign push        = port_sel ? acc_q[0] : I_DEC_VALID;
    assign push_data   = port_sel ? {fld_q[0], byte_q_in} : {f_q, I_DEC_DATA};
    assign O_DEC_READY = fifo_rdy && !port_sel;
    assign O_PORT_READY = fifo_rdy && port_sel;

    vxp_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk   (I_REF_CLK),
        .i_srst  (I_SRST),
        .i_data  (push_data),
        .i_valid (push),
        .o_ready (fifo_rdy),
        .o_data  ({O_SCL_FIELD, O_SCL_DATA}),
        .o_valid (O_SCL_VALID),
        .i_ready (I_SCL_READY)
    );

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SRST);

    a_status_byte: assert property (
        pix_en_q && st_q == ST_EAV && byte_q[1:0] == 2'h3 && !nocode
        |=> out_q[7] && out_q[4] && out_q[6:5] == {f_q, v_q})
        else $error("EAV status byte malformed");
    a_flags_at_eav: assert property (
        $changed({f_q, v_q}) |-> st_q == ST_EAV && byte_q == 11'h0)
        else $error("Field or vblank changed away from EAV");
    a_line4_525: assert property (
        st_q == ST_ACT && !std_q && !alt_q && line_q == 10'h004 |-> !f_q && v_q)
        else $error("525 line 4 flags wrong");
    a_line313_625: assert property (
        st_q == ST_ACT && std_q && !alt_q && line_q == L625_F_BEG |-> f_q && v_q)
        else $error("625 line 313 flags wrong");
    a_vertical_gate_window_active: assert property (
        st_q == ST_ACT && alt_q && line_q >= vs_q && line_q < ve_q |-> !v_q)
        else $error("Vblank set inside gate window");
    a_blank_pair: assert property (
        !code_q && !act_q |-> out_q == BLANK_LO || out_q == BLANK_HI)
        else $error("Blanking byte not 80h or 10h");
    a_codes_off: assert property (
        pix_en_q && nocode |=> !code_q)
        else $error("Timing code sent while suppressed");
    a_gated_accept: assert property (
        I_GATED_CLOCK_MODE[0] && pin_rise[CLK_B] && !I_PORT_OUT_EN |=> acc_q[0])
        else $error("Gated clock byte not accepted");
    a_qual_block: assert property (
        !I_GATED_CLOCK_MODE[0] && !(lvl_d[QUAL_B] ^ I_QUALIFIER_POLARITY[0]) |=> !acc_q[0])
        else $error("Byte accepted with qualifier inactive");
    a_source_sel: assert property (
        I_PORT_OUT_EN && I_DEC_VALID && fifo_rdy |-> push && !O_PORT_READY)
        else $error("Port source used in output mode");
    a_emb_field: assert property (
        I_EMBEDDED_CODES && code_hit |=> fld_q[0] == $past(lvl_d[6]))
        else $error("Embedded field bit not taken");

    c_sav_sent: cover property (pix_en_q && st_q == ST_SAV && byte_q[1:0] == 2'h3);
    c_code_seen: cover property (code_hit && I_EMBEDDED_CODES);
    c_fifo_full: cover property (!fifo_rdy);
    c_field_two: cover property ($rose(f_q));

endmodule : vxp_port

`default_nettype wire

// ### verif/vxp_src.sv
`timescale 1ns/100ps
`default_nettype none
module vxp_src;
    logic       clk = 1'b0;
    logic [7:0] dat = 8'h00;
    logic       dq  = 1'b0;
    logic       hr  = 1'b0;
    logic       vr  = 1'b0;
    // ----------------------------------------
    // One byte per clock, clock idle between bytes
    // ----------------------------------------
    task automatic send(input logic [7:0] b, input logic q);
    begin
        dat = b;
        dq = q;
        #62.5 clk = 1'b1;
        #62.5 clk = 1'b0;
    end
    endtask : send
endmodule : vxp_src
`default_nettype wire

// ### verif/test_video_expansion_port.sv
`timescale 1ns/100ps
`default_nettype none
module test_video_expansion_port
    import vxp_pkg::*;
;
    logic       clk = 1'b0;
    logic       srst = 1'b1, oen = 1'b1, s625 = 1'b0, dv = 1'b0, rdy = 1'b0, emb = 1'b0;
    logic [2:0] otc = OTC_ITU, fmt = 3'h0;
    logic [1:0] src = SRC_PORT, fdv = 2'h0, hcfg = 2'h0, pol = 2'h0, gck = 2'h3, fdh = 2'h0;
    logic [3:0] vcfg = 4'hF;
    logic [7:0] pd, sd, vd;
    logic       poe, fo, vo, drdy, prdy, sf, sv, vv;
    logic [2:0] sfmt;
    logic [1:0] ht, vt, inf;
    logic [7:0] ot [8] = '{8'hFF, 8'h00, 8'h00, 8'hF0, 8'h80, 8'h10, 8'h80, 8'h10};
    int         bad_count = 0, check_count = 0, hn = 0, vn = 0, qn = 0, i, h0;

    vxp_src u_src();
    vxp_port DUT (
        .I_REF_CLK(clk), .I_SRST(srst), .I_PORT_OUT_EN(oen), .I_STD_625(s625),
        .I_OUTPUT_TIMING_CODE_SELECT(otc), .I_VERTICAL_GATE_WINDOW_START_LINE(10'h001), .I_VERTICAL_GATE_WINDOW_STOP_LINE(10'h003),
        .I_DEC_DATA(8'h5A), .I_DEC_VALID(dv), .O_DEC_READY(drdy), .O_PORT_DATA_BUS(pd),
        .O_PORT_DATA_BUS_OE(poe), .O_FIELD(fo), .O_VBLANK(vo), .I_PORT_DATA_BUS(u_src.dat),
        .I_PORT_CLOCK(u_src.clk), .I_PORT_QUALIFIER(u_src.dq), .I_PORT_HORIZONTAL_REF(u_src.hr),
        .I_PORT_VERTICAL_REF(u_src.vr), .I_EMBEDDED_CODES(emb), .I_SCALER_SOURCE_SELECT(src),
        .I_INPUT_FORMAT_SELECT(fmt), .I_FIELD_DETECT_VERTICAL_CFG(fdv), .I_FIELD_DETECT_HORIZONTAL_CFG(fdh),
        .I_VERTICAL_TRIGGER_EDGE_CFG(vcfg), .I_HORIZONTAL_TRIGGER_EDGE_CFG(hcfg), .I_QUALIFIER_POLARITY(pol),
        .I_GATED_CLOCK_MODE(gck), .O_PORT_READY(prdy), .O_SCL_DATA(sd), .O_SCL_FIELD(sf),
        .O_SCL_VALID(sv), .I_SCL_READY(rdy), .O_SCL_FORMAT(sfmt), .O_H_TRIG(ht), .O_V_TRIG(vt),
        .O_IN_FIELD(inf), .O_VBI_DATA(vd), .O_VBI_VALID(vv));

    initial
    begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        hn <= hn + int'(ht[0] === 1'b1);
        vn <= vn + int'(vt[0] === 1'b1);
        qn <= qn + int'(vv === 1'b1);
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    begin
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    end
    endtask : chk

    task automatic tick(input int n);
    begin
        repeat (n) @(posedge clk);
        #1;
    end
    endtask : tick

    task automatic rst;
    begin
        srst = 1'b1;
        tick(12);
        srst = 1'b0;
    end
    endtask : rst

    task automatic end_sim;
    begin
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask : end_sim

    // ----------------------------------------
    // Output stream, then input path
    // ----------------------------------------
    initial
    begin
        rst;
        tick(3);
        chk("oe", 8'h01, {7'h0, poe});
        chk("field", 8'h01, {7'h0, fo});
        chk("vblank", 8'h01, {7'h0, vo});
        chk("dec ready", 8'h01, {7'h0, drdy});
        for (i = 0; i < 8; i++)
        begin
            chk("out", ot[i], pd & ((i == 3) ? 8'hF0 : 8'hFF));
            tick(4);
        end
        // Gate window 1 to 3: line 2 is active although standard timing blanks it
        otc = OTC_VERTICAL_GATE_WINDOW;
        rst;
        tick(6864);
        chk("gate vblank", 8'h00, {7'h0, vo});
        chk("line 2 field", 8'h01, {7'h0, fo});
        otc = OTC_NOCODE;
        s625 = 1'b1;
        rst;
        tick(3);
        for (i = 0; i < 8; i++)
        begin
            chk("nocode", i[0] ? BLANK_HI : BLANK_LO, pd);
            tick(4);
        end
        oen = 1'b0;
        dv = 1'b1;
        rst;
        tick(4);
        // Nine bytes into an eight word buffer while the scaler stalls
        for (i = 0; i < 9; i++)
            u_src.send(8'hA0 + 8'(i), 1'b1);
        tick(6);
        chk("vbi", 8'h09, 8'(qn));
        chk("vbi data", 8'hA8, vd);
        chk("full", 8'h00, {7'h0, prdy});
        rdy = 1'b1;
        for (i = 0; i < 8; i++)
        begin
            chk("scl", 8'hA0 + 8'(i), sd);
            chk("scl field", 8'h00, {7'h0, sf});
            tick(1);
        end
        rdy = 1'b0;
        chk("empty", 8'h00, {7'h0, sv});
        chk("dec ready", 8'h00, {7'h0, drdy});
        gck = 2'h0;
        u_src.send(8'h11, 1'b0);
        tick(6);
        chk("dq hi", 8'h00, {7'h0, sv});
        pol = 2'h3;
        u_src.send(8'h22, 1'b0);
        tick(6);
        chk("dq lo", 8'h22, sd);
        for (i = 0; i < 8; i++)
        begin
            fmt = 3'(i);
            tick(1);
            chk("fmt", 8'(i), {5'h0, sfmt});
        end
        for (i = 0; i < 2; i++)
        begin
            hcfg = 2'(3 * i);
            h0 = hn;
            u_src.hr = 1'b1;
            tick(8);
            u_src.hr = 1'b0;
            tick(8);
            chk("htrig", 8'h01, 8'(hn - h0));
        end
        h0 = vn;
        fdv = 2'h3;
        u_src.vr = 1'b1;
        tick(8);
        chk("field", 8'h03, {6'h0, inf});
        u_src.vr = 1'b0;
        tick(8);
        chk("vtrig", 8'h02, 8'(vn - h0));
        fdv = 2'h0;
        fdh = 2'h1;
        u_src.hr = 1'b1;
        tick(8);
        u_src.vr = 1'b1;
        tick(8);
        chk("phase field", 8'h02, {6'h0, inf});
        u_src.hr = 1'b0;
        u_src.vr = 1'b0;
        tick(8);
        // Protection bits of the status byte carry junk on purpose
        h0 = vn;
        emb = 1'b1;
        u_src.send(8'hFF, 1'b0);
        u_src.send(8'h00, 1'b0);
        u_src.send(8'h00, 1'b0);
        u_src.send(8'hE5, 1'b0);
        tick(6);
        chk("code field", 8'h03, {6'h0, inf});
        chk("code vtrig", 8'h01, 8'(vn - h0));
        end_sim;
    end

    initial
    begin
        #200us;
        bad_count++;
        end_sim;
    end
endmodule : test_video_expansion_port
`default_nettype wire
